//--- src/monitor_ctrl_pkg.sv
// package: register map, field layout, reset values and carriers of the monitor control bank
package monitor_ctrl_pkg;

    // register offsets
    localparam logic [7:0] CONVERTER_CONTROL_ADDR      = 8'h30;
    localparam logic [7:0] PIN_AND_POWER_CONTROL_ADDR  = 8'h31;
    localparam logic [7:0] BALANCE_OUTPUT_CONTROL_ADDR = 8'h32;
    localparam logic [7:0] CONVERSION_TRIGGER_ADDR     = 8'h34;

    // converter_control fields
    localparam int CONVERSION_TRIGGER_FORCE_ON_BIT = 6;
    localparam int TEMP_SEL_HI       = 5;
    localparam int TEMP_SEL_LO       = 4;
    localparam int GEN_ANALOG_BIT    = 3;
    localparam int CELL_SEL_HI       = 2;
    localparam int CELL_SEL_LO       = 0;

    // pin_and_power_control fields
    localparam int AUX_OUTPUT_BIT    = 7;
    localparam int GPIO_DRIVE_BIT    = 6;
    localparam int GPIO_LEVEL_BIT    = 5;
    localparam int SLEEP_BIT         = 2;
    localparam int THERM_RET_HI      = 1;
    localparam int THERM_RET_LO      = 0;

    // balance_output_control and trigger fields
    localparam int BALANCE_HI        = 5;
    localparam int TRIGGER_BIT       = 0;

    // widths and codes
    localparam int CELL_COUNT        = 6;
    localparam logic [2:0] CELL_CODE_MAX = 3'h5;

    // reset values
    localparam logic [7:0] CONVERTER_CONTROL_RST = 8'h00;
    localparam logic [7:0] PIN_POWER_CONTROL_RST = 8'h40;
    localparam logic [7:0] BALANCE_CONTROL_RST   = 8'h00;

    // writable masks: reserved bits store nothing and read zero
    localparam logic [7:0] CONVERTER_CONTROL_MASK = 8'h7f;
    localparam logic [7:0] PIN_POWER_WRITE_MASK   = 8'hc7;
    localparam logic [7:0] BALANCE_CONTROL_MASK   = 8'h3f;

    // timing
    localparam int  CLK_HZ           = 50_000_000;
    localparam real SLEEP_EXIT_MS    = 1.0;
    localparam int  SLEEP_EXIT_CYCLES = int'(SLEEP_EXIT_MS * real'(CLK_HZ) / 1000.0);
    localparam int  REF_SETTLE_CYCLES = 16;

    // selection handed to the converter at a sequence start
    typedef struct packed {
        logic [1:0] temperature_select;
        logic       general_analog_input;
        logic [5:0] cell_mask;
    } conversion_trigger_select_t;

    typedef enum logic [1:0] {
        CONVERSION_TRIGGER_IDLE   = 2'b00,
        CONVERSION_TRIGGER_SETTLE = 2'b01,
        CONVERSION_TRIGGER_RUN    = 2'b11
    } conversion_trigger_state_t;

endpackage

//--- src/monitor_adc_io_balance_ctrl.sv
// control register bank for the cell monitor converter, pins, sleep and balance outputs
// Behaviour
// - force-on bit keeps converter powered always
// - auto mode: power, settle, convert, power off
// - temperature select picks none, a, b, both
// - general analog input bit includes that input
// - cell code k measures cells 1..k+1
// - aux bit connects aux pin to regulator
// - pin drive bit: 0 pulls low, 1 releases
// - read-only bit reports synchronised pin level
// - sleep bit disables all protection comparators
// - wait 1 ms after sleep clears
// - thermistor return bits connect inputs to ground
// - balance register holds six bits, two reserved
// - balance bit drives its output, default low
// - trigger uses currently programmed converter settings
module monitor_adc_io_balance_ctrl
    import monitor_ctrl_pkg::*;
#(
    parameter int SLEEP_EXIT_CNT = SLEEP_EXIT_CYCLES,
    parameter int SETTLE_CNT     = REF_SETTLE_CYCLES
)
(
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // register port from the serial interface decoder
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    output logic [7:0]                 reg_rdata,
    // converter handshake
    input  wire logic                  conversion_trigger_done,
    output logic                       conversion_trigger_power,
    output logic                       conversion_trigger_start,
    output conversion_trigger_select_t               conversion_trigger_select,
    // pins and analog switches
    input  wire logic                  gpio_i,
    output logic                       gpio_o,
    output logic                       gpio_oe_n,
    output logic                       aux_connect,
    output logic [1:0]                 thermistor_return_switch,
    output logic [CELL_COUNT-1:0]      balance_output_pin,
    // protection comparator enables
    output logic                       comparators_enable
);

    // cell code to mask; illegal codes fall back to cell 1 only
    function automatic logic [5:0] cell_mask_of(input logic [2:0] code);
        logic [5:0] m;
        m = 6'h01;
        if (code <= CELL_CODE_MAX)
        begin
            for (int i = 1; i < CELL_COUNT; i++)
            begin
                if (3'(i) <= code)
                begin
                    m[i] = 1'b1;
                end
            end
        end
        return m;
    endfunction

    // register group
    logic [7:0] conversion_trigger_ctrl_q, conversion_trigger_ctrl_d;
    logic [7:0] pin_ctrl_q,  pin_ctrl_d;
    logic [7:0] bal_ctrl_q,  bal_ctrl_d;
    logic [7:0] rdata_q,     rdata_d;
    logic       trigger_req;

    // pin input synchroniser
    logic       gpio_meta_q, gpio_sync_q;

    always_comb
    begin
        conversion_trigger_ctrl_d = conversion_trigger_ctrl_q;
        pin_ctrl_d  = pin_ctrl_q;
        bal_ctrl_d  = bal_ctrl_q;
        trigger_req = 1'b0;
        if (reg_wr)
        begin
            unique case (reg_addr)
                CONVERTER_CONTROL_ADDR:
                    conversion_trigger_ctrl_d = reg_wdata & CONVERTER_CONTROL_MASK;
                PIN_AND_POWER_CONTROL_ADDR:
                    pin_ctrl_d = reg_wdata & PIN_POWER_WRITE_MASK;
                BALANCE_OUTPUT_CONTROL_ADDR:
                    bal_ctrl_d = reg_wdata & BALANCE_CONTROL_MASK;
                CONVERSION_TRIGGER_ADDR:
                    trigger_req = reg_wdata[TRIGGER_BIT];
                default:
                    ;
            endcase
        end
        // read-back; the pin level bit shows the live synchronised pin
        unique case (reg_addr)
            CONVERTER_CONTROL_ADDR:      rdata_d = conversion_trigger_ctrl_q;
            PIN_AND_POWER_CONTROL_ADDR:
            begin
                rdata_d = pin_ctrl_q;
                rdata_d[GPIO_LEVEL_BIT] = gpio_sync_q;
            end
            BALANCE_OUTPUT_CONTROL_ADDR: rdata_d = bal_ctrl_q;
            default:                     rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            conversion_trigger_ctrl_q <= CONVERTER_CONTROL_RST;
            pin_ctrl_q  <= PIN_POWER_CONTROL_RST;
            bal_ctrl_q  <= BALANCE_CONTROL_RST;
            rdata_q     <= 8'h00;
            gpio_meta_q <= 1'b1;
            gpio_sync_q <= 1'b1;
        end
        else
        begin
            conversion_trigger_ctrl_q <= conversion_trigger_ctrl_d;
            pin_ctrl_q  <= pin_ctrl_d;
            bal_ctrl_q  <= bal_ctrl_d;
            rdata_q     <= rdata_d;
            gpio_meta_q <= gpio_i;
            gpio_sync_q <= gpio_meta_q;
        end
    end

    // pin and switch outputs
    logic                  aux_q, gpio_oe_n_q;
    logic [1:0]            therm_q;
    logic [CELL_COUNT-1:0] bal_q;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            aux_q       <= 1'b0;
            gpio_oe_n_q <= 1'b1;
            therm_q     <= 2'h0;
            bal_q       <= '0;
        end
        else
        begin
            aux_q       <= pin_ctrl_d[AUX_OUTPUT_BIT];
            // drive bit 0 enables the low driver; 1 releases for input use
            gpio_oe_n_q <= pin_ctrl_d[GPIO_DRIVE_BIT];
            therm_q     <= pin_ctrl_d[THERM_RET_HI:THERM_RET_LO];
            bal_q       <= bal_ctrl_d[BALANCE_HI:0];
        end
    end

    // sleep and wake-up delay
    logic [$clog2(SLEEP_EXIT_CNT+1)-1:0] wake_cnt_q, wake_cnt_d;
    logic                                cmp_en_q, cmp_en_d;

    always_comb
    begin
        wake_cnt_d = wake_cnt_q;
        cmp_en_d   = cmp_en_q;
        if (pin_ctrl_d[SLEEP_BIT])
        begin
            // comparators go off at once; the wait restarts on each wake
            cmp_en_d   = 1'b0;
            wake_cnt_d = '0;
        end
        else if (!cmp_en_q)
        begin
            // the clearing edge counts as the first wait cycle, so a full
            // SLEEP_EXIT_CNT cycles pass before the comparators return
            if (wake_cnt_q == ($bits(wake_cnt_q))'(SLEEP_EXIT_CNT))
            begin
                cmp_en_d = 1'b1;
            end
            else
            begin
                wake_cnt_d = wake_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wake_cnt_q <= '0;
            cmp_en_q   <= 1'b1;
        end
        else
        begin
            wake_cnt_q <= wake_cnt_d;
            cmp_en_q   <= cmp_en_d;
        end
    end

    // converter power sequencer
    conversion_trigger_state_t                      state_q, state_d;
    logic [$clog2(SETTLE_CNT+1)-1:0]  settle_q, settle_d;
    logic                             power_q, power_d;
    logic                             start_q, start_d;
    conversion_trigger_select_t                     sel_q, sel_d;
    logic                             force_on;

    assign force_on = conversion_trigger_ctrl_q[CONVERSION_TRIGGER_FORCE_ON_BIT];

    always_comb
    begin
        state_d  = state_q;
        settle_d = settle_q;
        start_d  = 1'b0;
        sel_d    = sel_q;
        unique case (state_q)
            CONVERSION_TRIGGER_IDLE:
                if (trigger_req)
                begin
                    // selection frozen at the request from the programmed settings
                    sel_d.temperature_select   = conversion_trigger_ctrl_q[TEMP_SEL_HI:TEMP_SEL_LO];
                    sel_d.general_analog_input = conversion_trigger_ctrl_q[GEN_ANALOG_BIT];
                    sel_d.cell_mask = cell_mask_of(conversion_trigger_ctrl_q[CELL_SEL_HI:CELL_SEL_LO]);
                    settle_d = '0;
                    if (force_on)
                    begin
                        // already powered and settled, so no start-up wait
                        state_d = CONVERSION_TRIGGER_RUN;
                        start_d = 1'b1;
                    end
                    else
                    begin
                        state_d = CONVERSION_TRIGGER_SETTLE;
                    end
                end
            CONVERSION_TRIGGER_SETTLE:
                if (settle_q == ($bits(settle_q))'(SETTLE_CNT - 1))
                begin
                    state_d = CONVERSION_TRIGGER_RUN;
                    start_d = 1'b1;
                end
                else
                begin
                    settle_d = settle_q + 1'b1;
                end
            CONVERSION_TRIGGER_RUN:
                if (conversion_trigger_done)
                begin
                    state_d = CONVERSION_TRIGGER_IDLE;
                end
            default:
                state_d = CONVERSION_TRIGGER_IDLE;
        endcase
        power_d = force_on || (state_d != CONVERSION_TRIGGER_IDLE);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_q  <= CONVERSION_TRIGGER_IDLE;
            settle_q <= '0;
            power_q  <= 1'b0;
            start_q  <= 1'b0;
            sel_q    <= '0;
        end
        else
        begin
            state_q  <= state_d;
            settle_q <= settle_d;
            power_q  <= power_d;
            start_q  <= start_d;
            sel_q    <= sel_d;
        end
    end

    assign reg_rdata                = rdata_q;
    assign conversion_trigger_power               = power_q;
    assign conversion_trigger_start               = start_q;
    assign conversion_trigger_select              = sel_q;
    assign gpio_o                   = 1'b0;
    assign gpio_oe_n                = gpio_oe_n_q;
    assign aux_connect              = aux_q;
    assign thermistor_return_switch = therm_q;
    assign balance_output_pin       = bal_q;
    assign comparators_enable       = cmp_en_q;

endmodule

//--- tb/monitor_ctrl_chk.sv
// checker: port-level assertions for the monitor control bank
module monitor_ctrl_chk
    import monitor_ctrl_pkg::*;
#(
    parameter int SLEEP_EXIT_CNT = 20,
    parameter int SETTLE_CNT     = 16
)
(
    // clock and reset
    input wire logic                  ref_clk,
    input wire logic                  rst,
    // register port
    input wire logic [7:0]            reg_addr,
    input wire logic [7:0]            reg_wdata,
    input wire logic                  reg_wr,
    input wire logic [7:0]            reg_rdata,
    // converter
    input wire logic                  conversion_trigger_done,
    input wire logic                  conversion_trigger_power,
    input wire logic                  conversion_trigger_start,
    input wire conversion_trigger_select_t          conversion_trigger_select,
    // pins and switches
    input wire logic                  gpio_i,
    input wire logic                  gpio_o,
    input wire logic                  gpio_oe_n,
    input wire logic                  aux_connect,
    input wire logic [1:0]            thermistor_return_switch,
    input wire logic [CELL_COUNT-1:0] balance_output_pin,
    input wire logic                  comparators_enable
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire w31 = reg_wr && reg_addr == PIN_AND_POWER_CONTROL_ADDR;
    wire w32 = reg_wr && reg_addr == BALANCE_OUTPUT_CONTROL_ADDR;
    wire w30 = reg_wr && reg_addr == CONVERTER_CONTROL_ADDR;
    chk_bal_follow: assert property (
        w32 |=> balance_output_pin == $past(reg_wdata[5:0])) else $error("balance");
    chk_aux_follow: assert property (
        w31 |=> aux_connect == $past(reg_wdata[7])) else $error("aux");
    chk_drive_follow: assert property (
        w31 |=> gpio_oe_n == $past(reg_wdata[6]) && !gpio_o) else $error("pin drive");
    chk_ret_follow: assert property (
        w31 |=> thermistor_return_switch == $past(reg_wdata[1:0])) else $error("return");
    chk_sleep_off: assert property (
        w31 && reg_wdata[2] |=> !comparators_enable) else $error("sleep");
    // only eight cycles checked here, the full wait is counted by the bench
    chk_wake_wait: assert property (
        w31 && !reg_wdata[2] && !comparators_enable |=> !comparators_enable [*8])
        else $error("wake early");
    chk_start_pulse: assert property (
        conversion_trigger_start |=> !conversion_trigger_start) else $error("start pulse");
    chk_start_power: assert property (
        conversion_trigger_start |-> conversion_trigger_power) else $error("start unpowered");
    chk_force_power: assert property (
        w30 && reg_wdata[6] |-> ##[1:2] conversion_trigger_power) else $error("force on");
    chk_rsvd_zero: assert property (
        $past(reg_addr) == BALANCE_OUTPUT_CONTROL_ADDR |-> reg_rdata[7:6] == 2'h0)
        else $error("reserved");
    chk_unmap_zero: assert property (
        $past(reg_addr) == 8'h33 |-> reg_rdata == 8'h00) else $error("unmapped");
endmodule
bind monitor_adc_io_balance_ctrl monitor_ctrl_chk #(
    .SLEEP_EXIT_CNT(SLEEP_EXIT_CNT),
    .SETTLE_CNT    (SETTLE_CNT)
) chk_u (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .conversion_trigger_done(conversion_trigger_done),
    .conversion_trigger_power(conversion_trigger_power), .conversion_trigger_start(conversion_trigger_start), .conversion_trigger_select(conversion_trigger_select),
    .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe_n(gpio_oe_n), .aux_connect(aux_connect),
    .thermistor_return_switch(thermistor_return_switch),
    .balance_output_pin(balance_output_pin), .comparators_enable(comparators_enable)
);

//--- tb/test_monitor_adc_io_balance_ctrl.sv
// testbench: random and corner stimulus for the monitor control bank
module test_monitor_adc_io_balance_ctrl
    import monitor_ctrl_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;
    // short wake and settle counts keep the run brief
    localparam int SLP = 20;
    localparam int SET = 4;
    logic         ref_clk   = 1'b0;
    logic         rst       = 1'b1;
    logic [7:0]   reg_addr  = 8'h00;
    logic [7:0]   reg_wdata = 8'h00;
    logic         reg_wr    = 1'b0;
    logic         conversion_trigger_done = 1'b0;
    logic         ext_lvl   = 1'b1;
    logic [7:0]   reg_rdata;
    logic         conversion_trigger_power, conversion_trigger_start, gpio_o, gpio_oe_n, aux_connect, comparators_enable;
    conversion_trigger_select_t conversion_trigger_select;
    logic [1:0]   thermistor_return_switch;
    logic [5:0]   balance_output_pin;
    int           seed       = 97;
    int           mismatches = 0;
    int           n_compared = 0;
    // open-drain wire: low while driven, else the outside level
    wire          gpio_i = gpio_oe_n ? ext_lvl : gpio_o;
    always #10 ref_clk = ~ref_clk;
    monitor_adc_io_balance_ctrl #(.SLEEP_EXIT_CNT(SLP), .SETTLE_CNT(SET)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rdata(reg_rdata), .conversion_trigger_done(conversion_trigger_done),
        .conversion_trigger_power(conversion_trigger_power), .conversion_trigger_start(conversion_trigger_start), .conversion_trigger_select(conversion_trigger_select),
        .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe_n(gpio_oe_n), .aux_connect(aux_connect),
        .thermistor_return_switch(thermistor_return_switch),
        .balance_output_pin(balance_output_pin), .comparators_enable(comparators_enable));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        repeat (4) @(posedge ref_clk);
        #1 check(16'(reg_rdata), 16'(e));
    endtask
    task automatic wait_hi(input bit cmp, output int n);
        n = 0;
        while (((cmp ? comparators_enable : conversion_trigger_start) !== 1'b1) && n < 200)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask
    function automatic conversion_trigger_select_t exp_sel(input logic [7:0] c);
        exp_sel.temperature_select = c[5:4];
        exp_sel.general_analog_input = c[3];
        exp_sel.cell_mask = (c[2:0] > 3'h5) ? 6'h01 : 6'((7'h02 << c[2:0]) - 7'h01);
    endfunction
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        finish_test();
    end
    initial
    begin
        logic [7:0] d;
        int n;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        #1 check(16'({conversion_trigger_power, conversion_trigger_start, aux_connect, gpio_oe_n, comparators_enable,
            thermistor_return_switch, balance_output_pin}), 16'h0300);
        rdx(CONVERTER_CONTROL_ADDR, 8'h00);
        rdx(PIN_AND_POWER_CONTROL_ADDR, 8'h60);
        rdx(8'h33, 8'h00);
        repeat (16)
        begin
            d = $random(seed);
            wr(BALANCE_OUTPUT_CONTROL_ADDR, d);
            check(16'(balance_output_pin), 16'(d[5:0]));
            rdx(BALANCE_OUTPUT_CONTROL_ADDR, d & 8'h3f);
            d = $random(seed) & 8'hfb;
            @(posedge ref_clk) ext_lvl <= d[4];
            wr(PIN_AND_POWER_CONTROL_ADDR, d);
            check(16'({aux_connect, gpio_oe_n, thermistor_return_switch}),
                16'({d[7:6], d[1:0]}));
            rdx(PIN_AND_POWER_CONTROL_ADDR, (d & 8'hc3) | {2'h0, d[6] & d[4], 5'h0});
        end
        wr(PIN_AND_POWER_CONTROL_ADDR, 8'h40);
        for (int k = 0; k < 8; k++)
        begin
            d = $random(seed);
            d[6] = k[1];
            d[2:0] = k[2:0];
            wr(CONVERTER_CONTROL_ADDR, d);
            rdx(CONVERTER_CONTROL_ADDR, d & 8'h7f);
            wr(CONVERSION_TRIGGER_ADDR, 8'h01);
            wait_hi(1'b0, n);
            // start stands right after the taking edge when forced on, else after settling
            check(16'(n), 16'(d[6] ? 0 : SET));
            check(16'(conversion_trigger_select), 16'(exp_sel(d)));
            @(posedge ref_clk) conversion_trigger_done <= 1'b1;
            @(posedge ref_clk) conversion_trigger_done <= 1'b0;
            @(posedge ref_clk);
            #1 check(16'(conversion_trigger_power), 16'(d[6]));
        end
        rdx(CONVERSION_TRIGGER_ADDR, 8'h00);
        wr(PIN_AND_POWER_CONTROL_ADDR, 8'h44);
        check(16'(comparators_enable), 16'h0000);
        wr(PIN_AND_POWER_CONTROL_ADDR, 8'h40);
        wait_hi(1'b1, n);
        check(16'(n), 16'(SLP));
        finish_test();
    end
endmodule
